// ==== src/output_router_map.svh ====
// Constants for the output assignment router: register offsets, fields, source codes and timing.
`ifndef OUTPUT_ROUTER_MAP_SVH
`define OUTPUT_ROUTER_MAP_SVH
// Register offsets (byte addresses, one 32-bit word each).
`define ORT_CTRL 8'h00
`define ORT_ASSIGN 8'h04
`define ORT_POLARITY 8'h08
`define ORT_SP_WRITE 8'h0C
`define ORT_SP_ACTIVE 8'h10
`define ORT_STATUS 8'h14
`define ORT_MASK 8'h18
`define ORT_SP_BANK 8'h1C
// Control register fields.
`define ORT_CTRL_HEATCOOL 0
`define ORT_CTRL_PROG_ON 1
`define ORT_CTRL_CONFIRM 2
`define ORT_CTRL_BANK_LSB 4
`define ORT_CTRL_PROTECT_LSB 8
// Protect level that blocks set point edits.
`define ORT_PROTECT_LOCK 2'h3
// Source codes held in each four-bit assignment field.
`define ORT_SRC_NONE 4'h0
`define ORT_SRC_HEAT 4'h1
`define ORT_SRC_COOL 4'h2
`define ORT_SRC_ALM1 4'h3
`define ORT_SRC_ALM2 4'h4
`define ORT_SRC_ALM3 4'h5
`define ORT_SRC_PEND 4'h6
`define ORT_SRC_WORK 4'h7
`define ORT_SRC_HEATER 4'h8
// Status bits.
`define ORT_ST_SP_COMMIT 0
`define ORT_ST_SP_REJECT 1
`define ORT_ST_MODE_RELOAD 2
// Times, in milliseconds, and the clock rate in kilohertz.
`define ORT_CLK_KHZ 200000
`define ORT_ALARM_HOLD_MS 2000
`define ORT_SP_COMMIT_MS 2000
`endif

// ==== src/output_router_pkg.sv ====
// Types shared by the output assignment router.
package output_router_pkg;
  // Set point commit sequencer states.
  typedef enum logic [1:0] {
    sp_idle,
    sp_pending
  } sp_state_e;
  // Four-bit output source selector.
  typedef logic [3:0] src_sel_t;
endpackage

// ==== src/output_source_mux.sv ====
// One output channel: source selection, optional inversion and registered drive.
`timescale 1ns/1ps
`include "output_router_map.svh"
module output_source_mux (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] sel,
  input wire logic [8:0] funcs,
  input wire logic invert,
  input wire logic hold_off,
  output logic drive,
  output logic lamp
);
  // Chosen function state; an unknown code selects nothing.
  wire logic chosen;
  assign chosen = (sel < 4'h9) ? funcs[sel] : 1'b0;
  // Pin level before registering; the hold keeps contacts open whatever the polarity.
  wire logic next_drive;
  assign next_drive = hold_off ? 1'b0 : (chosen ^ invert);

  // One register per output so every pin changes on a single edge.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drive <= 1'b0;
      lamp <= 1'b0;
    end else begin
      drive <= next_drive;
      lamp <= chosen;
    end
  end

  // A held output never closes its contacts.
  a_hold_open: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(hold_off) |-> !drive) else $error("held output was driven");
  // The indicator follows the uninverted function one cycle later.
  a_lamp_plain: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sys_rst |=> lamp == $past(chosen)) else $error("indicator not uninverted state");
endmodule // output_source_mux

// ==== src/output_assignment_router.sv ====
// Output assignment router with polarity, power-up hold and banked set points.
`timescale 1ns/1ps
`include "output_router_map.svh"
module output_assignment_router #(
  parameter bit HAS_CTRL2 = 1'b1,
  parameter int SP_WIDTH = 16,
  parameter int BANKS = 8,
  parameter int HOLD_CYCLES = `ORT_ALARM_HOLD_MS * (`ORT_CLK_KHZ),
  parameter int COMMIT_CYCLES = `ORT_SP_COMMIT_MS * (`ORT_CLK_KHZ)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic heat_out_in,
  input wire logic cool_out_in,
  input wire logic [2:0] alarm_in,
  input wire logic prog_end_in,
  input wire logic work_bit_in,
  input wire logic heater_fault_in,
  output logic ctrl_out1,
  output logic ctrl_out2,
  output logic [2:0] aux_out,
  output logic aux_indicator_first,
  output logic aux_indicator_second,
  output logic aux_indicator_third,
  output logic heater_fault_out,
  output logic [2:0] alarm_used,
  output logic irq
);
  // Software-visible configuration.
  logic heat_cool; // Control mode: 1 is heating/cooling.
  logic prog_on; // Program pattern is anything but off.
  logic [2:0] bank_sel; // Currently selected bank.
  logic [1:0] protect; // Operation/adjustment protect level.
  logic [3:0] asg [0:4]; // Assignments: ctrl1, ctrl2, aux1, aux2, aux3.
  logic [2:0] open_pol; // Per-aux open-in-alarm polarity.
  logic [SP_WIDTH-1:0] sp_bank [0:BANKS-1]; // Banked set points.
  logic [SP_WIDTH-1:0] sp_active; // Set point in force.
  logic [SP_WIDTH-1:0] sp_entry; // Value awaiting commit.
  logic [2:0] entry_bank; // Bank the pending value belongs to.
  logic [2:0] status; // Sticky event bits.
  logic [2:0] mask; // Interrupt enables.
  logic [31:0] hold_cnt; // Power-up alarm hold counter.
  logic [31:0] commit_cnt; // Set point commit counter.
  output_router_pkg::sp_state_e sp_state;

  // Mode-dependent default for a given output slot.
  // Slots: 0 is control one, 1 is control two, 2 to 4 are auxiliary one to three.
  function automatic logic [3:0] dflt(input int slot, input logic hc);
    logic [3:0] v;
    v = `ORT_SRC_NONE;
    if (slot == 0) v = `ORT_SRC_HEAT;
    else if (slot == 1) v = (hc && HAS_CTRL2) ? `ORT_SRC_COOL : `ORT_SRC_NONE;
    else if (slot == 2) v = `ORT_SRC_ALM1;
    else if (slot == 3) v = (hc && !HAS_CTRL2) ? `ORT_SRC_COOL : `ORT_SRC_ALM2;
    else if (slot == 4) v = `ORT_SRC_ALM3;
    return v;
  endfunction

  // Bus decode. Every strobe needs a full address match, so an access to an
  // unmapped offset changes nothing and reads back as zero.
  wire logic wr_ctrl = reg_wr && (reg_addr == `ORT_CTRL);
  wire logic wr_asg = reg_wr && (reg_addr == `ORT_ASSIGN);
  wire logic wr_pol = reg_wr && (reg_addr == `ORT_POLARITY);
  wire logic wr_sp = reg_wr && (reg_addr == `ORT_SP_WRITE);
  wire logic wr_mask = reg_wr && (reg_addr == `ORT_MASK);
  wire logic rd_status = reg_rd && (reg_addr == `ORT_STATUS);
  wire logic next_hc = reg_wdata[`ORT_CTRL_HEATCOOL];
  wire logic mode_change = wr_ctrl && (next_hc != heat_cool);
  wire logic confirm = wr_ctrl && reg_wdata[`ORT_CTRL_CONFIRM];
  wire logic sp_locked = (protect == `ORT_PROTECT_LOCK);
  wire logic sp_accept = wr_sp && !sp_locked;
  wire logic sp_reject = wr_sp && sp_locked;
  // A fresh edit in the cycle the timer runs out wins and restarts the delay,
  // so no commit event is flagged for a value that never took effect.
  wire logic commit_now = (sp_state == output_router_pkg::sp_pending) && !sp_accept &&
    (confirm || commit_cnt >= COMMIT_CYCLES - 1);
  // Alarm pins stay open until the counter reaches the hold length; the counter then
  // stops, so the hold can only come back through a reset.
  wire logic hold_off = (hold_cnt < HOLD_CYCLES);
  wire logic [2:0] events = {mode_change, sp_reject, commit_now};

  // Control register and mode-driven assignment reload.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      heat_cool <= 1'b0;
      prog_on <= 1'b0;
      bank_sel <= 3'h0;
      protect <= 2'h0;
      for (int i = 0; i < 5; i++) asg[i] <= dflt(i, 1'b0);
    end else if (wr_ctrl) begin
      // A control write carries every field; only a change of mode touches the map.
      heat_cool <= next_hc;
      prog_on <= reg_wdata[`ORT_CTRL_PROG_ON];
      bank_sel <= reg_wdata[`ORT_CTRL_BANK_LSB +: 3];
      protect <= reg_wdata[`ORT_CTRL_PROTECT_LSB +: 2];
      if (mode_change) for (int i = 0; i < 5; i++) asg[i] <= dflt(i, next_hc);
    end else if (wr_asg) begin
      // Software may place any source on any output, alarms included.
      for (int i = 0; i < 5; i++) asg[i] <= reg_wdata[4*i +: 4];
    end
  end

  // Polarity and mask registers; polarity defaults to close-in-alarm.
  // A write replaces all three polarities at once; each bit acts on its own aux pin, and bit zero also on the heater output.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      open_pol <= 3'h0;
      mask <= 3'h0;
    end else begin
      if (wr_pol) open_pol <= reg_wdata[2:0];
      if (wr_mask) mask <= reg_wdata[2:0];
    end
  end

  // Power-up hold counter; saturates once the hold has elapsed.
  // Thirty-two bits cover two seconds at the full clock rate with ample margin.
  always_ff @(posedge core_clk) begin
    if (sys_rst) hold_cnt <= 32'h0000_0000;
    else if (hold_off) hold_cnt <= hold_cnt + 32'h0000_0001;
  end

  // Set point entry and commit sequencer. A new edit restarts the delay.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sp_state <= output_router_pkg::sp_idle;
      commit_cnt <= 32'h0000_0000;
      sp_entry <= '0;
      entry_bank <= 3'h0;
      sp_active <= '0;
      for (int b = 0; b < BANKS; b++) sp_bank[b] <= '0;
    end else begin
      case (sp_state)
        output_router_pkg::sp_idle: begin
          if (sp_accept) begin
            sp_state <= output_router_pkg::sp_pending;
            commit_cnt <= 32'h0000_0000;
            sp_entry <= reg_wdata[SP_WIDTH-1:0];
            entry_bank <= bank_sel;
          end
        end
        default: begin
          // Pending: a new edit restarts, a confirm or expiry commits, else keep counting.
          if (sp_accept) begin
            commit_cnt <= 32'h0000_0000;
            sp_entry <= reg_wdata[SP_WIDTH-1:0];
            entry_bank <= bank_sel;
          end else if (commit_now) begin
            // The value always lands in its own bank, and is live only if that bank is.
            sp_state <= output_router_pkg::sp_idle;
            sp_bank[entry_bank] <= sp_entry;
            if (entry_bank == bank_sel) sp_active <= sp_entry;
          end else begin
            commit_cnt <= commit_cnt + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Sticky status; a set in the same cycle as the read clear wins.
  // This way an event that lands on the clearing read is never lost.
  always_ff @(posedge core_clk) begin
    if (sys_rst) status <= 3'h0;
    else status <= (rd_status ? 3'h0 : status) | events;
  end

  // Function vector indexed by source code.
  wire logic [8:0] funcs = {heater_fault_in, work_bit_in, prog_end_in, alarm_in,
    cool_out_in, heat_out_in, 1'b0};
  // Aux one carries program end when a program pattern is active.
  wire logic [3:0] aux1_sel = prog_on ? `ORT_SRC_PEND : asg[2];
  wire logic any_work = (asg[0] == `ORT_SRC_WORK) || (asg[1] == `ORT_SRC_WORK) ||
    (asg[2] == `ORT_SRC_WORK) || (asg[3] == `ORT_SRC_WORK) || (asg[4] == `ORT_SRC_WORK);
  logic [2:0] next_used;
  always_comb begin
    next_used = {3{any_work}};
    for (int i = 0; i < 5; i++) begin
      if (asg[i] == `ORT_SRC_ALM1) next_used[0] = 1'b1;
      if (asg[i] == `ORT_SRC_ALM2) next_used[1] = 1'b1;
      if (asg[i] == `ORT_SRC_ALM3) next_used[2] = 1'b1;
    end
  end
  wire logic ctrl2_sel_ok = HAS_CTRL2;

  // Channels. Control outputs are not alarm outputs, so they are never held.
  output_source_mux u_ctrl1 (.core_clk(core_clk), .sys_rst(sys_rst), .sel(asg[0]),
    .funcs(funcs), .invert(1'b0), .hold_off(1'b0), .drive(ctrl_out1), .lamp());
  // Without a second control output the slot is forced to select nothing.
  output_source_mux u_ctrl2 (.core_clk(core_clk), .sys_rst(sys_rst),
    .sel(ctrl2_sel_ok ? asg[1] : `ORT_SRC_NONE), .funcs(funcs), .invert(1'b0),
    .hold_off(1'b0), .drive(ctrl_out2), .lamp());
  output_source_mux u_aux1 (.core_clk(core_clk), .sys_rst(sys_rst), .sel(aux1_sel),
    .funcs(funcs), .invert(open_pol[0]), .hold_off(hold_off), .drive(aux_out[0]),
    .lamp(aux_indicator_first));
  output_source_mux u_aux2 (.core_clk(core_clk), .sys_rst(sys_rst), .sel(asg[3]),
    .funcs(funcs), .invert(open_pol[1]), .hold_off(hold_off), .drive(aux_out[1]),
    .lamp(aux_indicator_second));
  output_source_mux u_aux3 (.core_clk(core_clk), .sys_rst(sys_rst), .sel(asg[4]),
    .funcs(funcs), .invert(open_pol[2]), .hold_off(hold_off), .drive(aux_out[2]),
    .lamp(aux_indicator_third));
  // Heater and input error outputs follow the alarm one polarity.
  output_source_mux u_heater (.core_clk(core_clk), .sys_rst(sys_rst),
    .sel(`ORT_SRC_HEATER), .funcs(funcs), .invert(open_pol[0]), .hold_off(hold_off),
    .drive(heater_fault_out), .lamp());

  // Read data mux.
  // Decoded on the address alone; the strobe only gates the registered copy.
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_addr == `ORT_CTRL)
      next_rdata = {22'h0, protect, 1'b0, bank_sel, 2'h0, prog_on, heat_cool};
    else if (reg_addr == `ORT_ASSIGN)
      next_rdata = {12'h0, asg[4], asg[3], asg[2], asg[1], asg[0]};
    else if (reg_addr == `ORT_POLARITY) next_rdata = {29'h0, open_pol};
    else if (reg_addr == `ORT_SP_WRITE) next_rdata = 32'(sp_entry);
    else if (reg_addr == `ORT_SP_ACTIVE) next_rdata = 32'(sp_active);
    else if (reg_addr == `ORT_STATUS) next_rdata = {29'h0, status};
    else if (reg_addr == `ORT_MASK) next_rdata = {29'h0, mask};
    else if (reg_addr == `ORT_SP_BANK) next_rdata = 32'(sp_bank[bank_sel]);
  end

  // Registered read data, interrupt and alarm-use flags.
  // The interrupt looks at the next status value, so it rises with the event bit.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
      alarm_used <= 3'h0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      irq <= |(((rd_status ? 3'h0 : status) | events) & mask);
      alarm_used <= next_used;
    end
  end

  // Locked edits never reach the pending value.
  a_sp_locked: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_sp && sp_locked && sp_state == output_router_pkg::sp_idle) |=>
    sp_state == output_router_pkg::sp_idle) else $error("locked set point accepted");
  // A mode change reloads defaults one cycle later.
  a_mode_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_change |=> asg[0] == `ORT_SRC_HEAT && asg[2] == `ORT_SRC_ALM1)
    else $error("mode change did not reload");
  // Dual-output heat/cool puts cooling on control two.
  a_cool_route: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_change && next_hc && HAS_CTRL2) |=> asg[1] == `ORT_SRC_COOL &&
    asg[3] == `ORT_SRC_ALM2) else $error("cooling route wrong");
  // Program end replaces alarm one on aux one.
  a_prog_end: assert property (@(posedge core_clk) disable iff (sys_rst)
    prog_on |=> aux_indicator_first == $past(prog_end_in))
    else $error("program end not routed");
  // Work bit marks every alarm used.
  a_work_used: assert property (@(posedge core_clk) disable iff (sys_rst)
    any_work |=> alarm_used == 3'h7) else $error("work bit did not mark alarms");
  // Aux outputs stay open throughout the hold.
  a_aux_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($past(hold_off) && !$past(sys_rst)) |-> aux_out == 3'h0)
    else $error("aux closed during hold");
  // Confirm commits the pending value on the next edge.
  a_sp_confirm: assert property (@(posedge core_clk) disable iff (sys_rst)
    (commit_now && !sp_accept && entry_bank == bank_sel) |=> sp_active == $past(sp_entry))
    else $error("set point not committed");
  // Reset yields close-in-alarm polarity.
  a_pol_default: assert property (@(posedge core_clk)
    $past(sys_rst) |-> open_pol == 3'h0) else $error("polarity default wrong");
  // Open polarity on aux two inverts the pin against its indicator.
  a_aux_invert: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!hold_off && !$past(hold_off) && $past(open_pol[1]) && $past(!hold_off)) |->
    aux_out[1] != aux_indicator_second) else $error("open polarity not inverted");
  c_mode_change: cover property (@(posedge core_clk) mode_change);
  c_sp_commit: cover property (@(posedge core_clk) commit_now);
  c_sp_reject: cover property (@(posedge core_clk) sp_reject);
  c_irq: cover property (@(posedge core_clk) irq);
  c_prog_end: cover property (@(posedge core_clk) prog_on && prog_end_in);
  // The reject flag follows a locked edit.
  a_reject_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    sp_reject |=> status[`ORT_ST_SP_REJECT]) else $error("locked edit not flagged");
  // Alarm one polarity also governs the heater and input error output.
  a_heater_pol: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(hold_off) |-> heater_fault_out == ($past(heater_fault_in) ^ $past(open_pol[0])))
    else $error("heater output polarity wrong");
endmodule // output_assignment_router

// ==== verif/output_load_model.sv ====
// Behavioural relays and lamps that sit on the router's output pins.
`timescale 1ns/1ps
module output_load_model (
  input wire logic core_clk,
  input wire logic [2:0] aux_out,
  input wire logic ctrl_out1,
  input wire logic ctrl_out2,
  input wire logic heater_fault_out,
  output logic [2:0] relay_closed,
  output logic [1:0] ctrl_on,
  output logic fault_closed
);
  // A contact follows its coil one cycle late, taking the coil level seen at each rising edge.
  always_ff @(posedge core_clk) begin
    relay_closed <= aux_out;
    ctrl_on <= {ctrl_out2, ctrl_out1};
    fault_closed <= heater_fault_out;
  end
endmodule // output_load_model

// ==== verif/test_output_assignment_router.sv ====
// Self-checking testbench for the output assignment router.
`timescale 1ns/1ps
`include "output_router_map.svh"
module test_output_assignment_router;
  localparam int HOLD = 20; // Shortened power-up hold, in cycles.
  localparam int COMMIT = 30; // Shortened set point commit delay, in cycles.
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic heat_out_in = 1'b0, cool_out_in = 1'b0, prog_end_in = 1'b0;
  logic work_bit_in = 1'b0, heater_fault_in = 1'b0;
  logic [2:0] alarm_in = 3'h0;
  logic [31:0] reg_rdata, rdata_single;
  logic ctrl_out1, ctrl_out2, ind1, ind2, ind3, heater_fault_out, irq, fault_closed;
  logic [2:0] aux_out, alarm_used, relay_closed;
  logic [1:0] ctrl_on;
  logic [5:0] exp_pins = 6'h00; // Expected aux, control and heater contacts.
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'he250_4149;
  // Model state: assignment words of both variants, settings and sticky status.
  logic [31:0] m_asg = 32'h0005_4301, m_asg_single = 32'h0005_4301;
  logic [2:0] m_pol = 3'h0, m_st = 3'h0, m_bank = 3'h0;
  logic [1:0] m_prot = 2'h0;
  logic m_hc = 1'b0, m_prog = 1'b0, m_held = 1'b1;
  int m_banks[8];

  // The clock toggles every half period of 2.5 ns.
  always #2.5 core_clk = ~core_clk;

  output_assignment_router #(.HAS_CTRL2(1'b1), .HOLD_CYCLES(HOLD), .COMMIT_CYCLES(COMMIT))
    output_assignment_router_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .heat_out_in(heat_out_in), .cool_out_in(cool_out_in), .alarm_in(alarm_in),
    .prog_end_in(prog_end_in), .work_bit_in(work_bit_in), .heater_fault_in(heater_fault_in),
    .ctrl_out1(ctrl_out1), .ctrl_out2(ctrl_out2), .aux_out(aux_out),
    .aux_indicator_first(ind1), .aux_indicator_second(ind2), .aux_indicator_third(ind3),
    .heater_fault_out(heater_fault_out), .alarm_used(alarm_used), .irq(irq));
  // The variant without a second control output shares the bus; only its map is compared.
  output_assignment_router #(.HAS_CTRL2(1'b0), .HOLD_CYCLES(HOLD), .COMMIT_CYCLES(COMMIT))
    output_assignment_router_inst_single (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_single), .heat_out_in(heat_out_in), .cool_out_in(cool_out_in),
    .alarm_in(alarm_in), .prog_end_in(prog_end_in), .work_bit_in(work_bit_in),
    .heater_fault_in(heater_fault_in), .ctrl_out1(), .ctrl_out2(), .aux_out(),
    .aux_indicator_first(), .aux_indicator_second(), .aux_indicator_third(),
    .heater_fault_out(), .alarm_used(), .irq());
  output_load_model output_load_model_inst (.core_clk(core_clk), .aux_out(aux_out),
    .ctrl_out1(ctrl_out1), .ctrl_out2(ctrl_out2), .heater_fault_out(heater_fault_out),
    .relay_closed(relay_closed), .ctrl_on(ctrl_on), .fault_closed(fault_closed));

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Case equality so that an unknown never passes for a match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe; the next access waits an edge, so no strobe is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just then.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, "read data");
    if (a == `ORT_ASSIGN) check(rdata_single, m_asg_single, "single variant map");
    if (a == `ORT_STATUS) m_st = 3'h0;
  endtask

  // Writes the control word from the model's settings.
  task automatic ctrl(input logic confirm);
    wr(`ORT_CTRL, {22'h0, m_prot, 1'b0, m_bank, 1'b0, confirm, m_prog, m_hc});
  endtask

  // Mode defaults for both variants.
  task automatic reload();
    m_asg = m_hc ? 32'h0005_4321 : 32'h0005_4301;
    m_asg_single = m_hc ? 32'h0005_2301 : 32'h0005_4301;
    m_st[2] = 1'b1;
  endtask

  // Function level chosen by a source code.
  function automatic logic src(input logic [3:0] c);
    case (c)
      `ORT_SRC_HEAT: return heat_out_in;
      `ORT_SRC_COOL: return cool_out_in;
      `ORT_SRC_ALM1: return alarm_in[0];
      `ORT_SRC_ALM2: return alarm_in[1];
      `ORT_SRC_ALM3: return alarm_in[2];
      `ORT_SRC_PEND: return prog_end_in;
      `ORT_SRC_WORK: return work_bit_in;
      `ORT_SRC_HEATER: return heater_fault_in;
      default: return 1'b0;
    endcase
  endfunction

  // Compares the control, aux, heater, indicator and alarm-use pins with the model.
  task automatic check_pins();
    logic [2:0] f;
    logic [2:0] used;
    f[0] = m_prog ? prog_end_in : src(m_asg[11:8]);
    f[1] = src(m_asg[15:12]);
    f[2] = src(m_asg[19:16]);
    used = 3'h0;
    for (int i = 0; i < 20; i += 4) begin
      if (m_asg[i +: 4] >= `ORT_SRC_ALM1 && m_asg[i +: 4] <= `ORT_SRC_ALM3)
        used[m_asg[i +: 4] - 3] = 1'b1;
      if (m_asg[i +: 4] == `ORT_SRC_WORK) used = 3'h7;
    end
    // What the contacts should show one edge later, from the model alone.
    exp_pins = {(m_held ? 3'h0 : f ^ m_pol), src(m_asg[7:4]), src(m_asg[3:0]),
      (!m_held && (heater_fault_in ^ m_pol[0]))};
    check({ctrl_out1, ctrl_out2}, {src(m_asg[3:0]), src(m_asg[7:4])}, "control pins");
    check({aux_out, heater_fault_out}, m_held ? 4'h0 : {f ^ m_pol, heater_fault_in ^ m_pol[0]},
      "aux pins");
    if (!m_held) check({ind3, ind2, ind1}, f, "indicators");
    if (!m_prog) check(alarm_used, used, "alarms in use");
  endtask

  // New random function levels, checked one edge later.
  task automatic drive_random();
    @(posedge core_clk);
    {heat_out_in, cool_out_in, alarm_in, prog_end_in, work_bit_in, heater_fault_in} <=
      8'($random(seed));
    @(posedge core_clk);
    #1;
    check_pins();
    // Inputs hold still, so the loads now show what the pins showed an edge ago.
    @(posedge core_clk);
    #1;
    check({relay_closed, ctrl_on, fault_closed}, exp_pins, "load contacts");
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    complete_run();
  end

  initial begin
    for (int b = 0; b < 8; b++) m_banks[b] = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    heat_out_in <= 1'b1;
    // Defaults and the power-up hold, with every aux pin set to invert.
    rd(`ORT_ASSIGN, 32'h0005_4301);
    rd(`ORT_POLARITY, 32'h0);
    m_pol = 3'h7;
    wr(`ORT_POLARITY, 32'h0000_0007);
    @(posedge core_clk);
    #1 check_pins();
    repeat (HOLD) @(posedge core_clk);
    m_held = 1'b0;
    #1 check_pins();
    // Random maps, polarities and program pattern; codes cover the whole table.
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 20; i += 4) m_asg[i +: 4] = 4'($unsigned($random(seed)) % 9);
      m_asg_single = m_asg;
      m_pol = 3'($random(seed));
      m_prog = (n % 4 == 3);
      // The bus stands for an operator who has already entered the access password.
      wr(`ORT_ASSIGN, m_asg);
      wr(`ORT_POLARITY, {29'h0, m_pol});
      ctrl(1'b0);
      repeat (3) drive_random();
    end
    // Mode change both ways, first unmasked then masked.
    m_prog = 1'b0;
    wr(`ORT_MASK, 32'h0000_0004);
    rd(`ORT_STATUS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      m_hc = ~m_hc;
      ctrl(1'b0);
      reload();
      @(posedge core_clk);
      #1 check(irq, k == 0, "interrupt after reload");
      rd(`ORT_ASSIGN, m_asg);
      rd(`ORT_STATUS, 32'h4);
      @(posedge core_clk);
      #1 check(irq, 1'b0, "interrupt after clear");
      repeat (2) drive_random();
      wr(`ORT_MASK, 32'h0);
    end
    // Edit under protect level three is refused.
    m_prot = `ORT_PROTECT_LOCK;
    ctrl(1'b0);
    wr(`ORT_SP_WRITE, 32'h0000_1234);
    m_st[1] = 1'b1;
    rd(`ORT_SP_BANK, 32'h0);
    rd(`ORT_STATUS, {29'h0, m_st});
    m_prot = 2'h0;
    ctrl(1'b0);
    // Timed commit: old value until the delay runs out, new value after.
    wr(`ORT_SP_WRITE, 32'h0000_00C8);
    rd(`ORT_SP_ACTIVE, 32'h0);
    repeat (COMMIT - 8) @(posedge core_clk);
    rd(`ORT_SP_ACTIVE, 32'h0);
    repeat (8) @(posedge core_clk);
    m_banks[0] = 200;
    m_st[0] = 1'b1;
    rd(`ORT_SP_ACTIVE, 32'h0000_00C8);
    rd(`ORT_STATUS, {29'h0, m_st});
    // Confirmed edits into every other bank, then every bank read back.
    for (int b = 1; b < 8; b++) begin
      m_bank = 3'(b);
      ctrl(1'b0);
      m_banks[b] = b * 100 + 7;
      wr(`ORT_SP_WRITE, m_banks[b]);
      ctrl(1'b1);
      rd(`ORT_SP_ACTIVE, m_banks[b]);
    end
    // The entry register still shows the last accepted edit.
    rd(`ORT_SP_WRITE, m_banks[7]);
    for (int b = 0; b < 8; b++) begin
      m_bank = 3'(b);
      ctrl(1'b0);
      rd(`ORT_SP_BANK, m_banks[b]);
    end
    // Unmapped place: writes vanish and reads give zero.
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    complete_run();
  end
endmodule // test_output_assignment_router
